// file: core/color_pixel_pipeline.sv
// colour and tone stage: white balance, colour matrix, hue and saturation,
// gamma and user lookup, with a one-shot auto white balance and registers.
// assumes pixels synchronous to core_clk, one pixel per valid cycle
`timescale 1ns/1ps
`include "pix_map.svh"
module color_pixel_pipeline #(
  parameter logic [11:0] WB_INIT = `WB_RST,
  parameter int SUM_W = 36
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire pix_pkg::reg_req_s regReq,
  output logic [31:0] regRdata,
  // model strap, high on colour models
  input wire logic colorModel,
  // pixel stream
  input wire pix_pkg::pixel_s pixIn,
  output pix_pkg::pixel_s pixOut
);
  import pix_pkg::*;

  function automatic int clampI(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [11:0] sat12(input int v);
    return 12'(clampI(v, 0, int'(`LUT_MAX)));
  endfunction

  function automatic coef_idx_e coefIdx(input ch_sel_e row, input ch_sel_e col);
    coef_idx_e idx;
    unique case ({row, col})
      {CH_RED, CH_GREEN}: idx = CI_RG;
      {CH_RED, CH_BLUE}: idx = CI_RB;
      {CH_GREEN, CH_RED}: idx = CI_GR;
      {CH_GREEN, CH_BLUE}: idx = CI_GB;
      {CH_BLUE, CH_RED}: idx = CI_BR;
      {CH_BLUE, CH_GREEN}: idx = CI_BG;
      default: idx = CI_DIAG;
    endcase
    return idx;
  endfunction

  function automatic logic encFull(input encoding_e e);
    return e inside {ENC_BAYER8_FULL, ENC_BAYER10_FULL, ENC_BAYER12_FULL,
                     ENC_RGB8, ENC_BGR8, ENC_YUV411, ENC_YUV422};
  endfunction

  function automatic logic encWb(input encoding_e e);
    return encFull(e) || (e inside {ENC_BAYER8, ENC_BAYER10, ENC_BAYER12});
  endfunction

  function automatic logic [11:0] wbMul(input logic [11:0] x, input logic [11:0] g);
    return sat12((int'(x) * int'(g)) >>> 8);
  endfunction

  function automatic logic [11:0] ccmChan(input logic [11:0] base,
      input logic [11:0] o1, input logic [11:0] o2,
      input logic [9:0] c1, input logic [9:0] c2);
    int b;
    b = int'(base);
    return sat12(b + ((int'($signed(c1)) * (int'(o1) - b)
                     + int'($signed(c2)) * (int'(o2) - b)) >>> 8));
  endfunction

  // parabolic sine, Q8, degrees in -180..180
  function automatic int sinQ8(input int d);
    int a;
    int s;
    a = (d < 0) ? -d : d;
    s = (a * (int'(`HALF_TURN) - a) * int'(`SIN_RECIP)) >>> int'(`SIN_SHIFT);
    return (d < 0) ? -s : s;
  endfunction

  function automatic logic [11:0] isqrt24(input logic [23:0] v);
    logic [11:0] root;
    logic [23:0] sq;
    root = '0;
    sq = '0;
    for (int i = 11; i >= 0; i--) begin
      root[i] = 1'b1;
      sq = {12'h000, root} * {12'h000, root};
      if (sq > v) begin
        root[i] = 1'b0;
      end
    end
    return root;
  endfunction

  // blend from identity toward a square-root curve by weight w (Q8)
  function automatic logic [11:0] gammaCh(input logic [11:0] x, input int w);
    int s;
    s = int'(isqrt24({x, 12'h000}));
    return sat12(int'(x) + ((w * (s - int'(x))) >>> 8));
  endfunction

  // control registers
  logic [8:0] gammaQ, gammaD;
  logic [8:0] hueQ, hueD;
  logic [9:0] satQ, satD;
  wb_sel_e wbSelQ, wbSelD;
  logic [11:0] gainRQ, gainRD, gainBQ, gainBD;
  ch_sel_e rowQ, rowD, colQ, colD;
  logic [5:0][9:0] coefQ, coefD;
  logic lutOnQ, lutOnD;
  logic [11:0] lutIdxQ, lutIdxD;
  encoding_e encQ, encD;
  logic [31:0] rdDataQ, rdDataD;
  logic rdLutQ, rdLutD;
  coef_idx_e selIdx;

  // auto white balance
  awb_state_e stateQ, stateD;
  logic [SUM_W-1:0] sumRQ, sumRD, sumGQ, sumGD, sumBQ, sumBD;
  logic [11:0] resRQ, resRD;
  logic awbOkQ, awbOkD;
  logic awbGo, awbBusy, awbWrite, divStart, divDone, divOvf;
  logic [11:0] divQuot, divGain;
  logic [SUM_W-1:0] divDen;

  // pipeline
  pixel_s s1Q, s1D, s2Q, s2D, s3Q, s3D, s4Q, s4D, s5Q, s5D, outQ, outD;
  logic wbOn, colOn, lutWr;
  logic [3:0][11:0] lutAddr, lutRd;
  int sinV, cosV, cosArg, gw;

  assign wbOn = colorModel && encWb(encQ);
  assign colOn = colorModel && encFull(encQ);
  assign selIdx = coefIdx(rowQ, colQ);
  assign awbBusy = (stateQ != AWB_IDLE);
  assign cosArg = int'($signed(hueQ)) + int'(`QUARTER_TURN);
  assign sinV = sinQ8(int'($signed(hueQ)));
  assign cosV = sinQ8((cosArg > int'(`HALF_TURN)) ? cosArg - int'(`FULL_TURN) : cosArg);
  assign gw = ((int'(`UNITY_Q8) - int'(gammaQ)) * int'(`GAMMA_WEIGHT)) >>> 8;
  assign divGain = divOvf ? `WB_MAX : 12'(clampI(int'(divQuot), int'(`WB_MIN),
                                                 int'(`WB_MAX)));

  always_comb begin
    gammaD = gammaQ;
    hueD = hueQ;
    satD = satQ;
    wbSelD = wbSelQ;
    gainRD = gainRQ;
    gainBD = gainBQ;
    rowD = rowQ;
    colD = colQ;
    coefD = coefQ;
    lutOnD = lutOnQ;
    lutIdxD = lutIdxQ;
    encD = encQ;
    rdDataD = '0;
    rdLutD = 1'b0;
    if (regReq.wr) begin
      unique case (regReq.addr)
        `OFS_GAMMA: gammaD = 9'(clampI(int'(regReq.wdata), int'(`GAMMA_MIN),
                                       int'(`GAMMA_RST)));
        `OFS_HUE: hueD = 9'(clampI(int'(regReq.wdata), int'($signed(`HUE_MIN)),
                                   int'(`HUE_MAX)));
        `OFS_SAT: satD = 10'(clampI(int'(regReq.wdata), 0, int'(`SAT_MAX)));
        `OFS_WB_SEL: begin
          if (regReq.wdata[31:2] == '0 && regReq.wdata[1:0] != 2'b11) begin
            wbSelD = wb_sel_e'(regReq.wdata[1:0]);
          end
        end
        `OFS_WB_GAIN: begin
          if (wbSelQ == WB_RED) begin
            gainRD = 12'(clampI(int'(regReq.wdata), int'(`WB_MIN), int'(`WB_MAX)));
          end else if (wbSelQ == WB_BLUE) begin
            gainBD = 12'(clampI(int'(regReq.wdata), int'(`WB_MIN), int'(`WB_MAX)));
          end
        end
        `OFS_CCM_ROW: begin
          if (regReq.wdata[31:2] == '0 && regReq.wdata[1:0] != 2'b11) begin
            rowD = ch_sel_e'(regReq.wdata[1:0]);
          end
        end
        `OFS_CCM_COL: begin
          if (regReq.wdata[31:2] == '0 && regReq.wdata[1:0] != 2'b11) begin
            colD = ch_sel_e'(regReq.wdata[1:0]);
          end
        end
        `OFS_CCM_COEF: begin
          if (selIdx != CI_DIAG) begin
            coefD[selIdx] = 10'(clampI(int'(regReq.wdata), int'($signed(`COEF_MIN)),
                                       int'(`COEF_MAX)));
          end
        end
        `OFS_LUT_ON: lutOnD = regReq.wdata[0];
        `OFS_LUT_IDX: lutIdxD = 12'(clampI(int'(regReq.wdata), 0, int'(`LUT_MAX)));
        `OFS_ENCODING: begin
          if (regReq.wdata[31:4] == '0 && regReq.wdata[3:0] <= ENC_YUV422) begin
            encD = encoding_e'(regReq.wdata[3:0]);
          end
        end
        default: ;
      endcase
    end
    // auto result overrides a same-cycle gain write
    if (awbWrite) begin
      gainRD = resRQ;
      gainBD = divGain;
    end
    if (regReq.rd) begin
      unique case (regReq.addr)
        `OFS_GAMMA: rdDataD = 32'(gammaQ);
        `OFS_HUE: rdDataD = 32'($signed(hueQ));
        `OFS_SAT: rdDataD = 32'(satQ);
        `OFS_WB_SEL: rdDataD = 32'(wbSelQ);
        `OFS_WB_GAIN: begin
          if (wbSelQ == WB_RED) begin
            rdDataD = 32'(gainRQ);
          end else if (wbSelQ == WB_BLUE) begin
            rdDataD = 32'(gainBQ);
          end
        end
        `OFS_AWB: rdDataD = 32'(awbBusy);
        `OFS_CCM_ROW: rdDataD = 32'(rowQ);
        `OFS_CCM_COL: rdDataD = 32'(colQ);
        `OFS_CCM_COEF: rdDataD = (selIdx == CI_DIAG) ? 32'(`UNITY_Q8)
                                 : 32'($signed(coefQ[selIdx]));
        `OFS_LUT_ON: rdDataD = 32'(lutOnQ);
        `OFS_LUT_IDX: rdDataD = 32'(lutIdxQ);
        `OFS_LUT_VAL: rdLutD = 1'b1;
        `OFS_ENCODING: rdDataD = 32'(encQ);
        `OFS_STATUS: rdDataD = {29'h0, colorModel, awbOkQ, awbBusy};
        default: rdDataD = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gammaQ <= `GAMMA_RST;
      hueQ <= `HUE_RST;
      satQ <= `SAT_RST;
      wbSelQ <= WB_NONE;
      gainRQ <= WB_INIT;
      gainBQ <= WB_INIT;
      rowQ <= CH_RED;
      colQ <= CH_RED;
      coefQ <= {`COEF_BG_RST, `COEF_BR_RST, `COEF_GB_RST,
                `COEF_GR_RST, `COEF_RB_RST, `COEF_RG_RST};
      lutOnQ <= 1'b0;
      lutIdxQ <= `LUT_RST;
      encQ <= ENC_MONO8;
      rdDataQ <= '0;
      rdLutQ <= 1'b0;
    end else begin
      gammaQ <= gammaD;
      hueQ <= hueD;
      satQ <= satD;
      wbSelQ <= wbSelD;
      gainRQ <= gainRD;
      gainBQ <= gainBD;
      rowQ <= rowD;
      colQ <= colD;
      coefQ <= coefD;
      lutOnQ <= lutOnD;
      lutIdxQ <= lutIdxD;
      encQ <= encD;
      rdDataQ <= rdDataD;
      rdLutQ <= rdLutD;
    end
  end

  assign regRdata = rdLutQ ? 32'(lutRd[3]) : rdDataQ;

  assign awbGo = regReq.wr && regReq.addr == `OFS_AWB && regReq.wdata[0] && wbOn;
  assign divDen = (stateQ == AWB_ACCUM) ? sumRQ : sumBQ;

  always_comb begin
    stateD = stateQ;
    sumRD = sumRQ;
    sumGD = sumGQ;
    sumBD = sumBQ;
    resRD = resRQ;
    awbOkD = awbOkQ;
    divStart = 1'b0;
    awbWrite = 1'b0;
    unique case (stateQ)
      AWB_IDLE: begin
        // pass only where white balance applies
        if (awbGo) begin
          stateD = AWB_WAIT;
        end
      end
      AWB_WAIT: begin
        if (pixIn.valid && pixIn.frameStart) begin
          sumRD = SUM_W'(pixIn.r);
          sumGD = SUM_W'(pixIn.g);
          sumBD = SUM_W'(pixIn.b);
          stateD = AWB_ACCUM;
        end
      end
      AWB_ACCUM: begin
        if (pixIn.valid && pixIn.frameStart) begin
          divStart = 1'b1;
          stateD = AWB_DIVR;
        end else if (pixIn.valid) begin
          sumRD = sumRQ + SUM_W'(pixIn.r);
          sumGD = sumGQ + SUM_W'(pixIn.g);
          sumBD = sumBQ + SUM_W'(pixIn.b);
        end
      end
      AWB_DIVR: begin
        if (divDone) begin
          resRD = divGain;
          divStart = 1'b1;
          stateD = AWB_DIVB;
        end
      end
      AWB_DIVB: begin
        if (divDone) begin
          awbOkD = (sumRQ != '0) && (sumBQ != '0);
          awbWrite = awbOkD;
          stateD = AWB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ <= AWB_IDLE;
      sumRQ <= '0;
      sumGQ <= '0;
      sumBQ <= '0;
      resRQ <= `WB_MIN;
      awbOkQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      sumRQ <= sumRD;
      sumGQ <= sumGD;
      sumBQ <= sumBD;
      resRQ <= resRD;
      awbOkQ <= awbOkD;
    end
  end

  ratio_div #(.W(SUM_W), .QW(12), .FRAC(8)) awbDiv (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(divStart),
    .num(sumGQ),
    .den(divDen),
    .done(divDone),
    .ovf(divOvf),
    .quot(divQuot)
  );

  assign lutWr = regReq.wr && regReq.addr == `OFS_LUT_VAL;
  assign lutAddr = {lutIdxQ, s4Q.b, s4Q.g, s4Q.r};

  lookup_mem #(.AW(12), .DW(12), .NRD(4)) lutMem (
    .core_clk(core_clk),
    .wrEn(lutWr),
    .wrAddr(lutIdxQ),
    .wrData(12'(clampI(int'(regReq.wdata), 0, int'(`LUT_MAX)))),
    .rdAddr(lutAddr),
    .rdData(lutRd)
  );

  always_comb begin
    int y;
    int cr;
    int cb;
    int crR;
    int cbR;
    y = 0;
    cr = 0;
    cb = 0;
    crR = 0;
    cbR = 0;
    s1D = pixIn;
    s2D = s1Q;
    s3D = s2Q;
    s4D = s3Q;
    s5D = s4Q;
    outD = s5Q;
    if (wbOn) begin
      s1D.r = wbMul(pixIn.r, gainRQ);
      s1D.b = wbMul(pixIn.b, gainBQ);
    end
    if (colOn) begin
      s2D.r = ccmChan(s1Q.r, s1Q.g, s1Q.b, coefQ[CI_RG], coefQ[CI_RB]);
      s2D.g = ccmChan(s1Q.g, s1Q.r, s1Q.b, coefQ[CI_GR], coefQ[CI_GB]);
      s2D.b = ccmChan(s1Q.b, s1Q.r, s1Q.g, coefQ[CI_BR], coefQ[CI_BG]);
    end
    // hue and saturation only where enabled
    if (colOn) begin
      y = (int'(s2Q.r) + 2 * int'(s2Q.g) + int'(s2Q.b)) >>> 2;
      cr = int'(s2Q.r) - y;
      cb = int'(s2Q.b) - y;
      crR = (cr * cosV + cb * sinV) >>> 8;
      cbR = (cb * cosV - cr * sinV) >>> 8;
      crR = (crR * int'(satQ)) >>> 8;
      cbR = (cbR * int'(satQ)) >>> 8;
      s3D.r = sat12(y + crR);
      s3D.b = sat12(y + cbR);
      s3D.g = sat12(y - ((crR + cbR) >>> 1));
    end
    s4D.r = gammaCh(s3Q.r, gw);
    s4D.g = gammaCh(s3Q.g, gw);
    s4D.b = gammaCh(s3Q.b, gw);
    if (lutOnQ) begin
      outD.r = lutRd[0];
      outD.g = lutRd[1];
      outD.b = lutRd[2];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1Q <= '0;
      s2Q <= '0;
      s3Q <= '0;
      s4Q <= '0;
      s5Q <= '0;
      outQ <= '0;
    end else begin
      s1Q <= s1D;
      s2Q <= s2D;
      s3Q <= s3D;
      s4Q <= s4D;
      s5Q <= s5D;
      outQ <= outD;
    end
  end

  assign pixOut = outQ;
endmodule

// file: core/lookup_mem.sv
// level lookup memory: one write port, several registered read ports
// assumes writes and reads share core_clk; contents are not reset
`timescale 1ns/1ps
module lookup_mem #(
  parameter int AW = 12,
  parameter int DW = 12,
  parameter int NRD = 4
) (
  // clock
  input wire logic core_clk,
  // write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  // read ports
  input wire logic [NRD-1:0][AW-1:0] rdAddr,
  output logic [NRD-1:0][DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  for (genvar i = 0; i < NRD; i++) begin : gRd
    logic [DW-1:0] dataQ;
    always_ff @(posedge core_clk) begin
      dataQ <= mem[rdAddr[i]];
    end
    assign rdData[i] = dataQ;
  end
endmodule

// file: core/pix_map.svh
// register offsets, limits, reset values and fixed figures of the
// colour pixel pipeline; included by the pipeline and its register map users
// Notes on behaviour
// - gamma exponent 0.45 to 1.00, resets to 1.00, curve applied to output
// - hue rotates chroma phase, -180 to +180 degrees, resets to 0
// - saturation scales chroma, 0 to 2.0 times, resets to 1.3
// - hue and saturation only on colour models and full-colour encodings
// - white-balance selector none, red, blue; resets none; picks gain accessed
// - written gain 1.0 to 8.0 goes to selected component; initial value is a parameter
// - auto white balance command off or once; once runs one pass
// - successful auto pass writes computed red and blue gains
// - white balance and auto pass only on colour models, bayer, rgb, yuv encodings
// - matrix adds off-diagonal fractions of the other channels' differences
// - row and column selectors red, green, blue, reset red, address a coefficient
// - diagonal coefficients fixed at 1.0 and read back as 1.0
// - off-diagonal coefficient -1.0 to +0.99 stored at selected element
// - colour matrix only on colour models and full-colour encodings
// - 12-bit lookup table maps levels while enabled; enable resets off
// - lookup index and value 0 to 4095, index resets 0
`ifndef PIX_MAP_SVH
`define PIX_MAP_SVH

`define OFS_GAMMA 8'h00
`define OFS_HUE 8'h04
`define OFS_SAT 8'h08
`define OFS_WB_SEL 8'h0C
`define OFS_WB_GAIN 8'h10
`define OFS_AWB 8'h14
`define OFS_CCM_ROW 8'h18
`define OFS_CCM_COL 8'h1C
`define OFS_CCM_COEF 8'h20
`define OFS_LUT_ON 8'h24
`define OFS_LUT_IDX 8'h28
`define OFS_LUT_VAL 8'h2C
`define OFS_ENCODING 8'h30
`define OFS_STATUS 8'h34

`define UNITY_Q8 10'h100
`define GAMMA_MIN 9'h074
`define GAMMA_RST 9'h100
`define GAMMA_WEIGHT 10'h1D1
`define HUE_MIN 9'h14C
`define HUE_MAX 9'h0B4
`define HUE_RST 9'h000
`define HALF_TURN 9'h0B4
`define QUARTER_TURN 9'h05A
`define FULL_TURN 10'h168
`define SIN_RECIP 9'h103
`define SIN_SHIFT 5'h0D
`define SAT_MAX 10'h200
`define SAT_RST 10'h14D
`define WB_MIN 12'h100
`define WB_MAX 12'h800
`define WB_RST 12'h100
`define COEF_MIN 10'h300
`define COEF_MAX 10'h0FD
`define COEF_RG_RST 10'h380
`define COEF_RB_RST 10'h026
`define COEF_GR_RST 10'h380
`define COEF_GB_RST 10'h3A6
`define COEF_BR_RST 10'h01A
`define COEF_BG_RST 10'h35A
`define LUT_MAX 12'hFFF
`define LUT_RST 12'h000

`endif

// file: core/pix_pkg.sv
// types shared by the colour pixel pipeline and its users
// assumes 12-bit pixel channels
package pix_pkg;

  typedef struct packed {
    logic valid;
    logic frameStart;
    logic lineEnd;
    logic [11:0] r;
    logic [11:0] g;
    logic [11:0] b;
  } pixel_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    WB_NONE = 2'b00,
    WB_RED = 2'b01,
    WB_BLUE = 2'b10
  } wb_sel_e;

  typedef enum logic [1:0] {
    CH_RED = 2'b00,
    CH_GREEN = 2'b01,
    CH_BLUE = 2'b10
  } ch_sel_e;

  typedef enum logic [2:0] {
    CI_RG = 3'b000,
    CI_RB = 3'b001,
    CI_GR = 3'b010,
    CI_GB = 3'b011,
    CI_BR = 3'b100,
    CI_BG = 3'b101,
    CI_DIAG = 3'b111
  } coef_idx_e;

  typedef enum logic [3:0] {
    ENC_MONO8 = 4'b0000,
    ENC_MONO10 = 4'b0001,
    ENC_MONO12 = 4'b0010,
    ENC_BAYER8 = 4'b0011,
    ENC_BAYER10 = 4'b0100,
    ENC_BAYER12 = 4'b0101,
    ENC_BAYER8_FULL = 4'b0110,
    ENC_BAYER10_FULL = 4'b0111,
    ENC_BAYER12_FULL = 4'b1000,
    ENC_RGB8 = 4'b1001,
    ENC_BGR8 = 4'b1010,
    ENC_YUV411 = 4'b1011,
    ENC_YUV422 = 4'b1100
  } encoding_e;

  typedef enum logic [2:0] {
    AWB_IDLE = 3'b000,
    AWB_WAIT = 3'b001,
    AWB_ACCUM = 3'b010,
    AWB_DIVR = 3'b011,
    AWB_DIVB = 3'b100
  } awb_state_e;

endpackage

// file: core/ratio_div.sv
// serial divider: quot = num * 2^FRAC / den, one quotient bit per cycle
// assumes start only while idle; ovf when den is zero or quotient too wide
`timescale 1ns/1ps
module ratio_div #(
  parameter int W = 36,
  parameter int QW = 12,
  parameter int FRAC = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // request
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  // answer
  output logic done,
  output logic ovf,
  output logic [QW-1:0] quot
);
  localparam int RW = W + QW;
  localparam int BW = $clog2(QW);

  logic [RW-1:0] remQ, remD, denQ, denD, trial;
  logic [QW-1:0] qQ, qD;
  logic [BW-1:0] bitQ, bitD;
  logic runQ, runD, doneQ, doneD, ovfQ, ovfD;

  always_comb begin
    trial = denQ << bitQ;
    remD = remQ;
    denD = denQ;
    qD = qQ;
    bitD = bitQ;
    runD = runQ;
    ovfD = ovfQ;
    doneD = 1'b0;
    if (start) begin
      remD = RW'(num) << FRAC;
      denD = RW'(den);
      qD = '0;
      bitD = BW'(QW - 1);
      if (den == '0 || RW'(num) >= (RW'(den) << (QW - FRAC))) begin
        ovfD = 1'b1;
        doneD = 1'b1;
        runD = 1'b0;
      end else begin
        ovfD = 1'b0;
        runD = 1'b1;
      end
    end else if (runQ) begin
      if (remQ >= trial) begin
        remD = remQ - trial;
        qD[bitQ] = 1'b1;
      end
      if (bitQ == '0) begin
        runD = 1'b0;
        doneD = 1'b1;
      end else begin
        bitD = bitQ - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      remQ <= '0;
      denQ <= '0;
      qQ <= '0;
      bitQ <= '0;
      runQ <= 1'b0;
      doneQ <= 1'b0;
      ovfQ <= 1'b0;
    end else begin
      remQ <= remD;
      denQ <= denD;
      qQ <= qD;
      bitQ <= bitD;
      runQ <= runD;
      doneQ <= doneD;
      ovfQ <= ovfD;
    end
  end

  assign done = doneQ;
  assign ovf = ovfQ;
  assign quot = qQ;
endmodule

// file: testbench/color_pixel_pipeline_asserts.sv
// port checker for the colour pixel pipeline
// assumes a single core_clk domain
`timescale 1ns/1ps
module color_pixel_pipeline_asserts #(
  parameter logic [11:0] WB_INIT = 12'h100,
  parameter int SUM_W = 36
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // watched ports
  input wire pix_pkg::reg_req_s regReq,
  input wire logic [31:0] regRdata,
  input wire logic colorModel,
  input wire pix_pkg::pixel_s pixIn,
  input wire pix_pkg::pixel_s pixOut
);
  import pix_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_diag;
    regReq.wr && regReq.addr == 8'h18 && regReq.wdata < 3 ##1 !regReq.wr
    ##1 regReq.wr && regReq.addr == 8'h1C && regReq.wdata == $past(regReq.wdata, 2)
    ##1 !regReq.wr ##1 regReq.rd && regReq.addr == 8'h20;
  endsequence
  sequence s_lut;
    regReq.wr && regReq.addr == 8'h28 && regReq.wdata < 32'h1000 ##1 !regReq.wr
    ##1 regReq.wr && regReq.addr == 8'h2C && regReq.wdata < 32'h1000
    ##1 !regReq.wr ##1 regReq.rd && regReq.addr == 8'h2C;
  endsequence
  chk_valid_latency: assert property (pixOut.valid == $past(pixIn.valid, 6))
    else $error("valid latency");
  chk_frame_latency: assert property (pixOut.frameStart == $past(pixIn.frameStart, 6))
    else $error("frame start latency");
  chk_line_latency: assert property (pixOut.lineEnd == $past(pixIn.lineEnd, 6))
    else $error("line end latency");
  chk_diag_one: assert property (s_diag |=> regRdata == 32'h100)
    else $error("diagonal not one");
  chk_lut_readback: assert property (s_lut |=> regRdata == $past(regReq.wdata, 3))
    else $error("lookup entry readback");
  chk_hue_range: assert property (regReq.rd && regReq.addr == 8'h04 |=>
    $signed(regRdata) >= -180 && $signed(regRdata) <= 180) else $error("hue range");
  chk_sat_range: assert property (regReq.rd && regReq.addr == 8'h08 |=>
    regRdata <= 32'h200) else $error("saturation range");
  chk_coef_range: assert property (regReq.rd && regReq.addr == 8'h20 |=>
    $signed(regRdata) >= -256 && $signed(regRdata) <= 256) else $error("coefficient range");
endmodule
bind color_pixel_pipeline color_pixel_pipeline_asserts #(.WB_INIT(WB_INIT), .SUM_W(SUM_W)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .regReq(regReq), .regRdata(regRdata),
  .colorModel(colorModel), .pixIn(pixIn), .pixOut(pixOut));

// file: testbench/pix_src.sv
// upstream pixel source: frames of W by H pixels, one every other cycle
// assumes the bench supplies pixel data; channels flip between pixels
`timescale 1ns/1ps
module pix_src #(
  parameter int W = 8,
  parameter int H = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // control and pixels
  input wire logic run,
  input wire logic [35:0] data,
  output pix_pkg::pixel_s pix,
  output logic idle
);
  import pix_pkg::*;
  int x, y;
  logic act, gap;
  assign idle = !act;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {x, y, act, gap, pix} <= '0;
    end else begin
      gap <= !gap;
      if (act && !gap) begin
        pix <= '{1'b1, x == 0 && y == 0, x == W - 1, data[35:24], data[23:12], data[11:0]};
        x <= (x == W - 1) ? 0 : x + 1;
        if (x == W - 1) begin
          y <= (y == H - 1) ? 0 : y + 1;
          // a frame is always finished whole
          if (y == H - 1) act <= run;
        end
      end else begin
        pix <= '{1'b0, 1'b0, 1'b0, ~pix.r, ~pix.g, ~pix.b};
        if (run) act <= 1'b1;
      end
    end
  end
endmodule

// file: testbench/tb.sv
// self-checking bench for the colour pixel pipeline
// assumes pix_src upstream and the bound port checker
`timescale 1ns/1ps
module tb;
  import pix_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, colorModel = 1'b1, run = 1'b0, idle;
  logic cst = 1'b0, chkPix = 1'b0, rdSeen = 1'b0;
  reg_req_s regReq = '0;
  logic [31:0] regRdata, rnd = 32'h697A, rq[$];
  pixel_s pixIn, pixOut;
  logic [38:0] pq[$], xm = '0;
  int n_fail = 0, compares = 0;
  logic [39:0] rt[12] = '{40'h00_00000100, 40'h04_00000000, 40'h08_0000014D, 40'h0C_00000000,
    40'h14_00000000, 40'h18_00000000, 40'h1C_00000000, 40'h20_00000100,
    40'h24_00000000, 40'h28_00000000, 40'h30_00000000, 40'h34_00000004};
  logic [71:0] wt[13] = '{72'h00_00000000_00000074, 72'h04_FFFFFF38_FFFFFF4C,
    72'h08_00000300_00000200, 72'h0C_00000001_00000001, 72'h10_00000900_00000800,
    72'h0C_00000003_00000001, 72'h18_00000001_00000001, 72'h1C_00000002_00000002,
    72'h20_00000200_000000FD, 72'h20_FFFFFE00_FFFFFF00, 72'h28_00001FFF_00000FFF,
    72'h40_00000005_00000000, 72'h00_00000100_00000100};

  color_pixel_pipeline u_dut (.core_clk(core_clk), .reset_n(reset_n), .regReq(regReq),
    .regRdata(regRdata), .colorModel(colorModel), .pixIn(pixIn), .pixOut(pixOut));
  pix_src u_src (.core_clk(core_clk), .reset_n(reset_n), .run(run),
    .data(cst ? 36'h100200080 : {rnd[3:0], rnd}), .pix(pixIn), .idle(idle));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic cmp(input string n, input logic [38:0] e, input logic [38:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    regReq <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regReq <= '{1'b0, 1'b1, a, 32'h0};
    rq.push_back(e);
    @(posedge core_clk);
    regReq <= '0;
  endtask

  task automatic end_of_test;
    cmp("pending", 39'h0, 39'(pq.size() + rq.size()));
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic frames(input int n);
    int i;
    run <= 1'b1;
    repeat (n) @(posedge core_clk);
    run <= 1'b0;
    for (i = 0; i < 400 && !idle; i++) @(posedge core_clk);
    if (!idle) begin
      n_fail++;
      end_of_test();
    end
    repeat (10) @(posedge core_clk);
  endtask

  // read data stand one cycle after the strobe
  always @(posedge core_clk) begin
    rnd <= lfsr(rnd);
    rdSeen <= regReq.rd;
    if (rdSeen) cmp("regRdata", {7'h0, rq.pop_front()}, {7'h0, regRdata});
    if (chkPix && pixIn.valid) pq.push_back(pixIn ^ xm);
    if (pixOut.valid && pq.size() > 0) cmp("pixOut", pq.pop_front(), pixOut);
  end

  initial begin
    int i;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 12; i++) rd(rt[i][39:32], rt[i][31:0]);
    $display("test reset values done");
    for (i = 0; i < 13; i++) begin
      wr(wt[i][71:64], wt[i][63:32]);
      rd(wt[i][71:64], wt[i][31:0]);
    end
    wr(8'h18, 32'h2);
    wr(8'h1C, 32'h2);
    rd(8'h20, 32'h100);
    $display("test settings done");
    // colour model on, mono encoding: stages off
    chkPix <= 1'b1;
    frames(60);
    $display("test pass-through done");
    for (i = 0; i < 4096; i++) begin
      wr(8'h28, i);
      wr(8'h2C, 32'hFFF ^ i);
    end
    wr(8'h28, 32'h5);
    wr(8'h2C, 32'hFFA);
    rd(8'h2C, 32'hFFA);
    wr(8'h24, 32'h1);
    wr(8'h30, 32'h9);
    colorModel <= 1'b0;
    xm <= 39'hFFFFFFFFF;
    frames(60);
    $display("test lookup done");
    // grey card of ratios 2 and 4 on bayer
    chkPix <= 1'b0;
    cst <= 1'b1;
    colorModel <= 1'b1;
    wr(8'h24, 32'h0);
    wr(8'h30, 32'h3);
    wr(8'h10, 32'h100);
    wr(8'h14, 32'h1);
    rd(8'h14, 32'h1);
    frames(120);
    repeat (100) @(posedge core_clk);
    rd(8'h34, 32'h6);
    rd(8'h10, 32'h200);
    wr(8'h0C, 32'h2);
    rd(8'h10, 32'h400);
    $display("test auto balance done");
    // gains 2 and 4 turn the card grey, full-colour stages keep grey
    wr(8'h30, 32'h6);
    xm <= 39'h300000280;
    chkPix <= 1'b1;
    frames(60);
    $display("test balanced grey done");
    repeat (4) @(posedge core_clk);
    end_of_test();
  end
endmodule
